//--- src/ftm_mode_ctrl.sv
// Mode and flag control of a fault-tolerant low-speed CAN line driver, with a Wishbone slave.
//
// Function
// - A wake-up is accepted only after the wake level has held for the whole filter time.
// - In the low-power modes the detectors for failures 3, 4 and 7 stay enabled.
// - After power-on inhibit_out is driven high and the battery power-on flag is set.
// - The power-on flag shows on error_n in logic-supply standby and clears on entering normal mode.
// - A low logic supply forces enable and standby_n low inside the block.
// - Over-temperature disables only the transmitter; everything else keeps working.
// - Normal mode drives inhibit high, error flag on error_n, bus data on rx, term_low to supply.
// - Logic-supply standby drives inhibit high, power-on flag on error_n, wake flag on rx.
// - A pending wake-up indication is released on entering normal mode.
// - Go-to-sleep floats inhibit, and a later 0/0 enters sleep with term_low on battery.
// - 0/0 without a prior go-to-sleep is battery standby, like sleep but inhibit driven high.
// - A dominant level on either bus line or wake_n low raises a wake request driving inhibit.
// - In normal mode error_n is low while any of the seven failures is present.
`timescale 1ns/1ps
module ftm_mode_ctrl import ftm_pkg::*; #(
	parameter int WAKE_CNT_W = FTM_WAKE_CNT_W
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic                 standby_n_i,
	input  wire logic                 enable_i,
	input  wire logic                 wake_n_i,
	input  wire logic                 canh_dom_i,
	input  wire logic                 canl_dom_i,
	input  wire logic [FTM_NFAIL-1:0] fail_i,
	input  wire logic                 vcc_low_i,
	input  wire logic                 over_temp_i,
	input  wire logic                 rx_bus_i,
	input  wire logic                 tx_data_i,
	output logic                      inhibit_out_o,
	output logic                      inhibit_out_oe_o,
	output logic                      error_n_o,
	output logic                      rx_out_o,
	output logic                      term_low_bat_o,
	output logic                      tx_enable_o,
	output logic                      tx_data_o,
	output logic [FTM_NFAIL-1:0]      fail_det_en_o,
	output logic                      irq_o
);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers.

	localparam int SYNC_W = FTM_NFAIL + 9;
	logic [SYNC_W-1:0] async_in;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	assign async_in = {fail_i, tx_data_i, rx_bus_i, over_temp_i, vcc_low_i,
		canl_dom_i, canh_dom_i, wake_n_i, enable_i, standby_n_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
		end
	end
	logic                 stb_s;
	logic                 en_s;
	logic                 wake_n_s;
	logic                 canh_s;
	logic                 canl_s;
	logic                 vcc_low_s;
	logic                 otemp_s;
	logic                 rx_s;
	logic                 txd_s;
	logic [FTM_NFAIL-1:0] fail_s;
	assign {fail_s, txd_s, rx_s, otemp_s, vcc_low_s, canl_s, canh_s, wake_n_s, en_s, stb_s} =
		sync2_reg;

	// Fail-safe: with the logic supply low both control inputs read as low.
	logic stb_eff;
	logic en_eff;
	assign stb_eff = stb_s && !vcc_low_s;
	assign en_eff  = en_s && !vcc_low_s;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Register bus.

	ftm_wb_req_t req;
	logic        bus_hit;
	logic        wr_stb;
	assign req     = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
		sel: wb_sel_i, dat: wb_dat_i};
	assign bus_hit = req.cyc && req.stb && !wb_ack_o;
	assign wr_stb  = bus_hit && req.we;

	// Applies byte enables to a write over the old register value.
	function automatic logic [31:0] byte_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic [31:0]           ctrl_reg;
	logic [FTM_IRQ_W-1:0]  irq_mask_reg;
	logic [WAKE_CNT_W-1:0] wake_term_reg;
	logic [31:0]           wake_term_wide;
	assign wake_term_wide = byte_merge({{(32-WAKE_CNT_W){1'b0}}, wake_term_reg}, req.dat,
		req.sel);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg      <= FTM_CTRL_RST;
			irq_mask_reg  <= FTM_IRQ_MASK_RST;
			wake_term_reg <= WAKE_CNT_W'(FTM_WAKE_FILTER_CY - 1);
		end else if (wr_stb) begin
			unique case (req.adr)
				FTM_ADR_CTRL: begin
					ctrl_reg <= byte_merge(ctrl_reg, req.dat, req.sel);
				end
				FTM_ADR_IRQ_MASK: begin
					if (req.sel[0]) begin
						irq_mask_reg <= req.dat[FTM_IRQ_W-1:0];
					end
				end
				FTM_ADR_WAKE_TERM: begin
					wake_term_reg <= wake_term_wide[WAKE_CNT_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Classic single cycle: ack one cycle after the strobe, dropped the cycle after.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Mode decoder.

	ftm_mode_t mode_reg;
	ftm_mode_t mode_next;
	always_comb begin
		unique case ({stb_eff, en_eff})
			2'b11: mode_next = FTM_NORMAL;
			2'b10: mode_next = FTM_VCC_STANDBY;
			2'b01: mode_next = FTM_GO_SLEEP;
			2'b00: begin
				if (mode_reg == FTM_GO_SLEEP || mode_reg == FTM_SLEEP) begin
					mode_next = FTM_SLEEP;
				end else begin
					mode_next = FTM_BAT_STANDBY;
				end
			end
		endcase
	end

	// Reset is battery power-on; after it the block sits in battery standby.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= FTM_BAT_STANDBY;
		end else begin
			mode_reg <= mode_next;
		end
	end

	logic low_power;
	logic enter_normal;
	assign low_power    = (mode_reg != FTM_NORMAL);
	assign enter_normal = (mode_next == FTM_NORMAL) && low_power;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Wake-up and power-on flags.

	logic wake_cond;
	logic wake_req;
	assign wake_cond = low_power && (!wake_n_s || canh_s || canl_s);
	ftm_wake_filter #(
		.CNT_W (WAKE_CNT_W)
	) u_wake_filter (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (wake_cond),
		.term_i (wake_term_reg),
		.req_o  (wake_req)
	);
	logic wake_pend_reg;
	logic por_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_pend_reg <= 1'b0;
		end else if (enter_normal) begin
			wake_pend_reg <= 1'b0;
		end else if (wake_req && low_power) begin
			wake_pend_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			por_reg <= 1'b1;
		end else if (enter_normal) begin
			por_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Pin outputs, decoded from the next mode so they follow it on the same edge.

	logic any_fail;
	assign any_fail = |fail_s;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inhibit_out_o    <= 1'b1;
			inhibit_out_oe_o <= 1'b1;
			term_low_bat_o   <= 1'b1;
			fail_det_en_o    <= FTM_FAIL_LOW_POWER;
		end else begin
			inhibit_out_o <= 1'b1;
			unique case (mode_next)
				FTM_NORMAL, FTM_VCC_STANDBY: begin
					inhibit_out_oe_o <= 1'b1;
					term_low_bat_o   <= 1'b0;
				end
				FTM_BAT_STANDBY: begin
					inhibit_out_oe_o <= 1'b1;
					term_low_bat_o   <= 1'b1;
				end
				FTM_GO_SLEEP, FTM_SLEEP: begin
					inhibit_out_oe_o <= wake_pend_reg || wake_req;
					term_low_bat_o   <= 1'b1;
				end
			endcase
			fail_det_en_o <= (mode_next == FTM_NORMAL) ? FTM_FAIL_ALL : FTM_FAIL_LOW_POWER;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			error_n_o <= 1'b0;
			rx_out_o  <= 1'b1;
		end else begin
			unique case (mode_next)
				FTM_NORMAL: begin
					error_n_o <= !any_fail;
					rx_out_o  <= rx_s;
				end
				FTM_VCC_STANDBY: begin
					error_n_o <= !por_reg;
					rx_out_o  <= !wake_pend_reg;
				end
				FTM_GO_SLEEP, FTM_SLEEP, FTM_BAT_STANDBY: begin
					error_n_o <= !wake_pend_reg;
					rx_out_o  <= !wake_pend_reg;
				end
			endcase
		end
	end

	// Over-temperature and software switch off only the transmitter stage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_enable_o <= 1'b0;
			tx_data_o   <= 1'b1;
		end else begin
			tx_enable_o <= (mode_next == FTM_NORMAL) && !otemp_s && !ctrl_reg[FTM_CTRL_TX_OFF];
			tx_data_o   <= txd_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky status, write one to clear, set wins.

	logic                 any_fail_d_reg;
	logic                 otemp_d_reg;
	logic [FTM_IRQ_W-1:0] irq_set;
	logic [FTM_IRQ_W-1:0] irq_clr;
	logic [FTM_IRQ_W-1:0] irq_stat_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			any_fail_d_reg <= 1'b0;
			otemp_d_reg    <= 1'b0;
		end else begin
			any_fail_d_reg <= any_fail;
			otemp_d_reg    <= otemp_s;
		end
	end

	always_comb begin
		irq_set                = '0;
		irq_set[FTM_IRQ_WAKE]  = wake_req && low_power && !wake_pend_reg;
		irq_set[FTM_IRQ_FAIL]  = any_fail && !any_fail_d_reg;
		irq_set[FTM_IRQ_OTEMP] = otemp_s && !otemp_d_reg;
		irq_set[FTM_IRQ_MODE]  = (mode_next != mode_reg);
	end

	assign irq_clr = (wr_stb && req.adr == FTM_ADR_IRQ_STAT && req.sel[0]) ?
		req.dat[FTM_IRQ_W-1:0] : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Read data.

	logic [31:0] status_word;
	always_comb begin
		status_word                                       = '0;
		status_word[FTM_ST_MODE_LSB +: 3]                 = mode_reg;
		status_word[FTM_ST_POR]                           = por_reg;
		status_word[FTM_ST_WAKE]                          = wake_pend_reg;
		status_word[FTM_ST_OTEMP]                         = otemp_s;
		status_word[FTM_ST_VCC_LOW]                       = vcc_low_s;
		status_word[FTM_ST_FAIL_LSB +: FTM_NFAIL]         = fail_s;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (bus_hit && !req.we) begin
			unique case (req.adr)
				FTM_ADR_CTRL:      wb_dat_o <= ctrl_reg;
				FTM_ADR_STATUS:    wb_dat_o <= status_word;
				FTM_ADR_IRQ_STAT:  wb_dat_o <= {{(32-FTM_IRQ_W){1'b0}}, irq_stat_reg};
				FTM_ADR_IRQ_MASK:  wb_dat_o <= {{(32-FTM_IRQ_W){1'b0}}, irq_mask_reg};
				FTM_ADR_WAKE_TERM: wb_dat_o <= {{(32-WAKE_CNT_W){1'b0}}, wake_term_reg};
				default:           wb_dat_o <= '0;
			endcase
		end else begin
			wb_dat_o <= '0;
		end
	end

endmodule

//--- src/ftm_pkg.sv
// Package with constants, register map and types of the fault-tolerant mode control block.
package ftm_pkg;

	// Wishbone register map, byte addresses.
	localparam logic [7:0] FTM_ADR_CTRL      = 8'h00;
	localparam logic [7:0] FTM_ADR_STATUS    = 8'h04;
	localparam logic [7:0] FTM_ADR_IRQ_STAT  = 8'h08;
	localparam logic [7:0] FTM_ADR_IRQ_MASK  = 8'h0C;
	localparam logic [7:0] FTM_ADR_WAKE_TERM = 8'h10;

	// Control register fields.
	localparam int FTM_CTRL_TX_OFF = 0;

	// Status register field positions.
	localparam int FTM_ST_MODE_LSB = 0;
	localparam int FTM_ST_POR      = 4;
	localparam int FTM_ST_WAKE     = 5;
	localparam int FTM_ST_OTEMP    = 6;
	localparam int FTM_ST_VCC_LOW  = 7;
	localparam int FTM_ST_FAIL_LSB = 8;

	// Interrupt bit positions, shared by status and mask.
	localparam int FTM_IRQ_WAKE  = 0;
	localparam int FTM_IRQ_FAIL  = 1;
	localparam int FTM_IRQ_OTEMP = 2;
	localparam int FTM_IRQ_MODE  = 3;
	localparam int FTM_IRQ_W     = 4;

	// Wiring failures and those still watched in the low-power modes (3, 4 and 7).
	localparam int              FTM_NFAIL          = 7;
	localparam logic [6:0]      FTM_FAIL_ALL       = 7'h7F;
	localparam logic [6:0]      FTM_FAIL_LOW_POWER = 7'h4C;

	// Reset values.
	localparam logic [31:0] FTM_CTRL_RST     = 32'h0000_0000;
	localparam logic [3:0]  FTM_IRQ_MASK_RST = 4'h0;

	// Wake-up filter time and its count at 200 MHz.
	localparam int FTM_CLK_MHZ        = 200;
	localparam int FTM_WAKE_FILTER_NS = 10000;
	localparam int FTM_WAKE_FILTER_CY = (FTM_WAKE_FILTER_NS * FTM_CLK_MHZ + 999) / 1000;
	localparam int FTM_WAKE_CNT_W     = 16;

	// Operating modes selected by standby_n and enable.
	typedef enum logic [2:0] {
		FTM_NORMAL,
		FTM_VCC_STANDBY,
		FTM_GO_SLEEP,
		FTM_SLEEP,
		FTM_BAT_STANDBY
	} ftm_mode_t;

	// One Wishbone request as seen by the slave.
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ftm_wb_req_t;

endpackage

//--- src/ftm_wake_filter.sv
// Wake-up filter: asserts a request only after the wake condition persists for a full count.
`timescale 1ns/1ps
module ftm_wake_filter import ftm_pkg::*; #(
	parameter int CNT_W = FTM_WAKE_CNT_W
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             cond_i,
	input  wire logic [CNT_W-1:0] term_i,
	output logic                  req_o
);

	logic [CNT_W-1:0] cnt_reg;

	// The count restarts whenever the condition drops and holds at the terminal value.
	always_ff @(posedge clk_i) begin
		if (rst_i || !cond_i) begin
			cnt_reg <= '0;
		end else if (cnt_reg != term_i) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_o <= 1'b0;
		end else begin
			req_o <= cond_i && (cnt_reg == term_i);
		end
	end

endmodule

//--- dv/ftm_host_model.sv
// Host model that drives the two mode pins of the block.
`timescale 1ns/1ps
module ftm_host_model (
	input  wire logic       clk_i,
	input  wire logic [1:0] cmd_i,
	input  wire logic       vcc_low_i,
	output logic            standby_n_o = 1'b0,
	output logic            enable_o = 1'b0
);
	// The command is {standby_n, enable}; 1/0 reads the power-on flag.
	always @(posedge clk_i) begin
		standby_n_o <= cmd_i[1];
		// An unpowered host cannot hold enable high.
		enable_o <= cmd_i[0] && !vcc_low_i;
	end
endmodule

//--- dv/ftm_mode_monitor.sv
// Checker of bus timing and mode outputs of the mode control block.
`timescale 1ns/1ps
module ftm_mode_monitor import ftm_pkg::*; #(
	parameter int WAKE_CNT_W = FTM_WAKE_CNT_W
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        standby_n_i,
	input wire logic        enable_i,
	input wire logic [6:0]  fail_i,
	input wire logic        vcc_low_i,
	input wire logic        over_temp_i,
	input wire logic        inhibit_out_o,
	input wire logic        inhibit_out_oe_o,
	input wire logic        error_n_o,
	input wire logic        term_low_bat_o,
	input wire logic        tx_enable_o,
	input wire logic [6:0]  fail_det_en_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////////////
	property p_por;
		$fell(rst_i) |-> inhibit_out_oe_o && inhibit_out_o && !error_n_o && term_low_bat_o;
	endproperty
	a_por: assert property (p_por) else $error("power-on outputs wrong");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack_one;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_dat;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_dat: assert property (p_dat) else $error("read data outside ack");
	property p_normal;
		(standby_n_i && enable_i && !vcc_low_i && fail_i == 7'h00)[*4] |=> error_n_o
			&& inhibit_out_oe_o && !term_low_bat_o && fail_det_en_o == FTM_FAIL_ALL;
	endproperty
	a_normal: assert property (p_normal) else $error("normal outputs wrong");
	property p_fail;
		(standby_n_i && enable_i && !vcc_low_i && fail_i != 7'h00)[*4] |=> !error_n_o;
	endproperty
	a_fail: assert property (p_fail) else $error("error flag missing");
	property p_vcc_stby;
		(standby_n_i && !enable_i && !vcc_low_i)[*4] |=> inhibit_out_oe_o && !term_low_bat_o;
	endproperty
	a_vcc_stby: assert property (p_vcc_stby) else $error("standby outputs wrong");
	property p_vcc_low;
		vcc_low_i[*4] |=> term_low_bat_o && fail_det_en_o == FTM_FAIL_LOW_POWER;
	endproperty
	a_vcc_low: assert property (p_vcc_low) else $error("fail-safe not forced");
	property p_otemp;
		over_temp_i[*4] |=> !tx_enable_o;
	endproperty
	a_otemp: assert property (p_otemp) else $error("transmitter on while hot");
	c_ack: cover property (wb_ack_o);
	c_sleep: cover property (!inhibit_out_oe_o);
	c_hot: cover property (over_temp_i && !tx_enable_o);
endmodule
bind ftm_mode_ctrl ftm_mode_monitor #(.WAKE_CNT_W(WAKE_CNT_W)) ftm_mode_monitor_inst (.*);

//--- dv/test_fault_tolerant_bus_mode_control.sv
// Self-checking bench of the mode control block with its host model.
`timescale 1ns/1ps
module test_fault_tolerant_bus_mode_control import ftm_pkg::*; ();
	localparam int WT = 3;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	ftm_wb_req_t req = '0;
	logic [31:0] wb_dat_o;
	logic [6:0]  fail_i = 7'h00;
	logic [6:0]  fail_en;
	logic [1:0]  cmd = 2'b00;
	logic        wb_ack_o, stb_n, en, inhibit_out, inh_oe, error_n_o, rx_out_o, term_bat, tx_en, tx_o;
	logic        irq_o, wake_n_i = 1'b1, canh_i = 1'b0, vcc_low_i = 1'b0, otemp_i = 1'b0;
	logic        rx_bus_i = 1'b1, canl_i = 1'b0, txd_i = 1'b1;
	int          bad_count = 0;
	int          checked = 0;
	int          cycles = 0;
	ftm_host_model ftm_host_model_inst (.clk_i(clk_i), .cmd_i(cmd), .vcc_low_i(vcc_low_i),
		.standby_n_o(stb_n), .enable_o(en));
	ftm_mode_ctrl ftm_mode_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc),
		.wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel),
		.wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .standby_n_i(stb_n),
		.enable_i(en), .wake_n_i(wake_n_i), .canh_dom_i(canh_i), .canl_dom_i(canl_i),
		.fail_i(fail_i), .vcc_low_i(vcc_low_i), .over_temp_i(otemp_i), .rx_bus_i(rx_bus_i),
		.tx_data_i(txd_i), .inhibit_out_o(inhibit_out), .inhibit_out_oe_o(inh_oe),
		.error_n_o(error_n_o), .rx_out_o(rx_out_o), .term_low_bat_o(term_bat),
		.tx_enable_o(tx_en), .tx_data_o(tx_o), .fail_det_en_o(fail_en), .irq_o(irq_o));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count = bad_count + 1;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic cy(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rd);
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		req <= '0;
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] d;
		chk("inh_oe", 1, inh_oe);
		chk("error_n", 0, error_n_o);
		bus(0, FTM_ADR_STATUS, 0, d);
		chk("mode", FTM_BAT_STANDBY, d[2:0]);
		chk("por", 1, d[FTM_ST_POR]);
		bus(0, FTM_ADR_WAKE_TERM, 0, d);
		chk("wake_term", FTM_WAKE_FILTER_CY - 1, d);
		bus(0, 8'h40, 0, d);
		chk("unmapped", 0, d);
		bus(1, FTM_ADR_WAKE_TERM, WT, d);
		$display("reset test done");
	endtask
	task automatic t_standby();
		logic [31:0] d;
		cmd <= 2'b10;
		cy(6);
		chk("por_flag", 0, error_n_o);
		chk("rx_wake", 1, rx_out_o);
		chk("term_bat", 0, term_bat);
		cmd <= 2'b11;
		cy(6);
		bus(0, FTM_ADR_STATUS, 0, d);
		chk("mode", FTM_NORMAL, d[2:0]);
		chk("por", 0, d[FTM_ST_POR]);
		rx_bus_i <= 0;
		txd_i <= 0;
		cy(5);
		chk("rx_data", 0, rx_out_o);
		chk("tx_data", 0, tx_o);
		rx_bus_i <= 1;
		txd_i <= 1;
		cmd <= 2'b10;
		cy(6);
		chk("por_flag", 1, error_n_o);
		cmd <= 2'b11;
		cy(6);
		$display("standby test done");
	endtask
	task automatic t_fail();
		logic [31:0] d;
		bus(1, FTM_ADR_IRQ_STAT, 32'h0000_000F, d);
		bus(1, FTM_ADR_IRQ_MASK, 32'h0000_0002, d);
		fail_i <= 7'h04;
		cy(5);
		chk("error_n", 0, error_n_o);
		chk("irq", 1, irq_o);
		bus(0, FTM_ADR_STATUS, 0, d);
		chk("fail", 32'h0000_0004, d[15:8]);
		fail_i <= 7'h00;
		cy(5);
		chk("error_n", 1, error_n_o);
		chk("irq_sticky", 1, irq_o);
		bus(1, FTM_ADR_IRQ_STAT, 32'h0000_0002, d);
		cy(2);
		chk("irq", 0, irq_o);
		$display("failure test done");
	endtask
	task automatic t_otemp();
		logic [31:0] d;
		bus(1, FTM_ADR_IRQ_MASK, 0, d);
		otemp_i <= 1;
		rx_bus_i <= 0;
		cy(5);
		chk("tx_en", 0, tx_en);
		chk("rx_data", 0, rx_out_o);
		chk("irq_masked", 0, irq_o);
		bus(0, FTM_ADR_IRQ_STAT, 0, d);
		chk("hot_event", 1, d[FTM_IRQ_OTEMP]);
		rx_bus_i <= 1;
		otemp_i <= 0;
		cy(5);
		chk("tx_en", 1, tx_en);
		bus(1, FTM_ADR_CTRL, 32'h0000_0001 << FTM_CTRL_TX_OFF, d);
		bus(0, FTM_ADR_CTRL, 0, d);
		chk("ctrl", 32'h0000_0001 << FTM_CTRL_TX_OFF, d);
		cy(2);
		chk("tx_off", 0, tx_en);
		bus(1, FTM_ADR_CTRL, 0, d);
		cy(2);
		chk("tx_on", 1, tx_en);
		$display("temperature test done");
	endtask
	task automatic t_sleep();
		logic [31:0] d;
		cmd <= 2'b01;
		cy(6);
		chk("inh_oe", 0, inh_oe);
		// The supply drops and the host loses enable in go-to-sleep, so the block enters sleep.
		vcc_low_i <= 1;
		cy(6);
		chk("inh_oe", 0, inh_oe);
		chk("term_bat", 1, term_bat);
		chk("det_en", FTM_FAIL_LOW_POWER, fail_en);
		wake_n_i <= 0;
		cy(WT);
		wake_n_i <= 1;
		cy(8);
		chk("inh_oe", 0, inh_oe);
		wake_n_i <= 0;
		cy(WT + 9);
		chk("inh_oe", 1, inh_oe);
		wake_n_i <= 1;
		vcc_low_i <= 0;
		cy(6);
		chk("rx_wake", 0, rx_out_o);
		bus(0, FTM_ADR_STATUS, 0, d);
		chk("wake_pend", 1, d[FTM_ST_WAKE]);
		cmd <= 2'b11;
		cy(6);
		chk("rx_wake", 1, rx_out_o);
		bus(0, FTM_ADR_STATUS, 0, d);
		chk("wake_pend", 0, d[FTM_ST_WAKE]);
		$display("sleep test done");
	endtask
	task automatic t_bat_standby();
		cmd <= 2'b00;
		cy(6);
		chk("inh_oe", 1, inh_oe);
		chk("term_bat", 1, term_bat);
		chk("rx_wake", 1, rx_out_o);
		canh_i <= 1;
		cy(WT + 9);
		canh_i <= 0;
		chk("rx_wake", 0, rx_out_o);
		cmd <= 2'b11;
		cy(6);
		chk("rx_wake", 1, rx_out_o);
		cmd <= 2'b00;
		cy(6);
		chk("err_wake", 1, error_n_o);
		canl_i <= 1;
		cy(WT + 9);
		canl_i <= 0;
		chk("err_wake", 0, error_n_o);
		chk("rx_wake", 0, rx_out_o);
		cmd <= 2'b11;
		cy(6);
		chk("rx_wake", 1, rx_out_o);
		$display("battery standby test done");
	endtask
	initial begin
		cy(2);
		rst_i <= 1'b0;
		t_reset();
		t_standby();
		t_fail();
		t_otemp();
		t_sleep();
		t_bat_standby();
		finish_test();
	end
endmodule
